// File: hdl/uart_ctrl_pkg.sv
package uart_ctrl_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int WORD_W = 9;
    localparam int FIFO_DEPTH_DEF = 4;

    localparam logic [2:0] OFS_CTRL_ONE = 3'h0;
    localparam logic [2:0] OFS_CTRL_TWO = 3'h1;
    localparam logic [2:0] OFS_STATUS   = 3'h2;
    localparam logic [2:0] OFS_DATA     = 3'h3;
    localparam logic [2:0] OFS_DIVISOR  = 3'h4;

    // Control one: port enable, length select, ninth bits.
    localparam int C1_ENABLE   = 7;
    localparam int C1_LENGTH   = 6;
    localparam int C1_RX_NINTH = 1;
    localparam int C1_TX_NINTH = 0;
    localparam logic [7:0] C1_WMASK = 8'hc1;

    localparam int C2_HIGH_SPEED = 5;
    localparam int C2_ADDR_DET   = 4;
    localparam int C2_WAKE       = 3;
    localparam int C2_RX_IRQ     = 2;
    localparam int C2_IDLE_IRQ   = 1;
    localparam int C2_EMPTY_IRQ  = 0;

    localparam int ST_EMPTY   = 0;
    localparam int ST_IDLE    = 1;
    localparam int ST_AVAIL   = 2;
    localparam int ST_OVERRUN = 3;

    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
    localparam logic [7:0] DIVISOR_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET     = 8'h00;

    // Baud period is PRESCALE * (N + 1) system clocks.
    localparam int PRESCALE_LOW  = 64;
    localparam int PRESCALE_HIGH = 16;
    localparam logic [5:0] PRE_LOW_LAST  = 6'h3f;
    localparam logic [5:0] PRE_HIGH_LAST = 6'h0f;
endpackage

// File: hdl/uart_baud_addr_irq_ctrl.sv
// Operation
// - Baud is clock over 64 or 16 times N+1
// - Free running 8-bit timer sets baud period
// - Divisor 0 to 255, unsigned
// - Address bit set marks word as address
// - Address word raises interrupt when enabled
// - Address bit clear: no interrupt, data discarded
// - Receive falling edge wakes low power device
// - Wake disabled: receive edges never wake
// - Receive or overrun flag sets interrupt request
// - Receive enable clear blocks those flags
// - Transmit idle flag gated by its enable
// - Transmit empty flag gated by its enable
// - One data location serves both directions
// - Length select picks 8 or 9 bits
// - Empty flag cleared by status read, data write
// - Disable resets counter, buffers; keeps divisor
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module word_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         flush,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("word_fifo depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t d;
    logic        push;
    logic        pop;

    assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = q.rp + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
        // Flush discards anything queued, including a same-cycle push.
        if (flush) begin
            d.wp  = '0;
            d.rp  = '0;
            d.cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

module uart_baud_addr_irq_ctrl
    import uart_ctrl_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input  wire logic              CLK_SYS,
    input  wire logic              RSTN,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR_STB,
    input  wire logic              RD_STB,
    output logic [DATA_W-1:0]      RDATA,
    input  wire logic              RX_PIN,
    input  wire logic              LOW_POWER,
    output logic                   WAKE_REQ,
    output logic                   BAUD_TICK,
    output logic                   PORT_ACTIVE,
    output logic                   DATA_NINE,
    output logic [WORD_W-1:0]      TX_WORD,
    output logic                   TX_VALID,
    input  wire logic              TX_READY,
    input  wire logic              TX_IDLE,
    input  wire logic [WORD_W-1:0] RX_WORD,
    input  wire logic              RX_VALID,
    output logic                   IRQ_REQ
);
    typedef struct packed {
        logic [7:0]  ctrl1;
        logic [7:0]  ctrl2;
        logic [7:0]  divisor;
        logic [7:0]  rx_data;
        logic        rx_ninth;
        logic        avail;
        logic        overrun;
        logic        empty;
        logic        armed;
        logic [7:0]  timer;
        logic [5:0]  pre;
        logic        tick;
        logic [1:0]  rx_sync;
        logic        rx_last;
        logic        wake;
        logic        irq;
        logic [7:0]  rdata;
        logic [14:0] gap;
        logic        clean;
    } state_t;

    state_t q;
    state_t d;

    logic              en;
    logic              nine;
    logic              wr_data;
    logic              rd_data;
    logic              rd_status;
    logic              cfg_wr;
    logic              addr_bit;
    logic              accept;
    logic              falling;
    logic [5:0]        pre_last;
    logic              fifo_ready;
    logic [WORD_W-1:0] push_word;

    assign en        = q.ctrl1[C1_ENABLE];
    assign nine      = q.ctrl1[C1_LENGTH];
    assign wr_data   = WR_STB && ADDR == OFS_DATA;
    assign rd_data   = RD_STB && ADDR == OFS_DATA;
    assign rd_status = RD_STB && ADDR == OFS_STATUS;
    assign cfg_wr    = WR_STB && ADDR != OFS_DATA && ADDR != OFS_STATUS;
    assign pre_last  = q.ctrl2[C2_HIGH_SPEED] ? PRE_HIGH_LAST
                                              : PRE_LOW_LAST;

    // Address bit is bit 7 of an 8-bit word, bit 8 of a 9-bit one.
    assign addr_bit = nine ? RX_WORD[8] : RX_WORD[7];
    assign accept   = RX_VALID && en
                      && !(q.ctrl2[C2_ADDR_DET] && !addr_bit);
    assign falling  = q.rx_last && !q.rx_sync[1];

    assign push_word = {nine & q.ctrl1[C1_TX_NINTH], WDATA};

    word_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (CLK_SYS),
        .rst_n     (RSTN),
        .flush     (!en),
        .in_data   (push_word),
        .in_valid  (wr_data && en),
        .in_ready  (fifo_ready),
        .out_data  (TX_WORD),
        .out_valid (TX_VALID),
        .out_ready (TX_READY)
    );

    always_comb begin
        d       = q;
        d.rdata = 8'h00;
        d.tick  = 1'b0;

        if (WR_STB) begin
            unique case (ADDR)
                OFS_CTRL_ONE: d.ctrl1   = WDATA & C1_WMASK;
                OFS_CTRL_TWO: d.ctrl2   = WDATA;
                OFS_DIVISOR:  d.divisor = WDATA;
                default:      d.ctrl1   = d.ctrl1;
            endcase
        end

        if (RD_STB) begin
            unique case (ADDR)
                OFS_CTRL_ONE: d.rdata = {q.ctrl1[7:6], 4'h0,
                                         q.rx_ninth, 1'b0};
                OFS_CTRL_TWO: d.rdata = q.ctrl2;
                OFS_STATUS:   d.rdata = {4'h0, q.overrun, q.avail,
                                         TX_IDLE, q.empty};
                OFS_DATA:     d.rdata = q.rx_data;
                OFS_DIVISOR:  d.rdata = q.divisor;
                default:      d.rdata = 8'h00;
            endcase
        end

        // Status read while empty arms the clear; a data write fires it.
        if (rd_status && q.empty) begin
            d.armed = 1'b1;
        end
        if (wr_data && q.armed && q.empty && fifo_ready) begin
            d.empty = 1'b0;
            d.armed = 1'b0;
        end
        // Hand-off to the shifter sets the flag and beats the clear.
        if (TX_VALID && TX_READY) begin
            d.empty = 1'b1;
        end

        if (rd_data) begin
            d.avail = 1'b0;
        end
        if (rd_status) begin
            d.overrun = 1'b0;
        end
        // A word arriving on a full register is lost and flagged.
        if (accept) begin
            if (q.avail && !rd_data) begin
                d.overrun = 1'b1;
            end else begin
                d.rx_data  = RX_WORD[7:0];
                d.rx_ninth = nine & RX_WORD[8];
                d.avail    = 1'b1;
            end
        end

        // Timer counts N down to 0; prescaler counts those wraps.
        if (q.timer == 8'h00) begin
            d.timer = q.divisor;
            if (q.pre >= pre_last) begin
                d.pre  = 6'h00;
                d.tick = 1'b1;
            end else begin
                d.pre = q.pre + 6'h01;
            end
        end else begin
            d.timer = q.timer - 8'h01;
        end

        // Disable restarts the baud counter; divisor and config stay.
        if (!en) begin
            d.timer   = q.divisor;
            d.pre     = 6'h00;
            d.tick    = 1'b0;
            d.avail   = 1'b0;
            d.overrun = 1'b0;
            d.empty   = 1'b1;
            d.armed   = 1'b0;
        end

        d.rx_sync = {q.rx_sync[0], RX_PIN};
        d.rx_last = q.rx_sync[1];
        // Only the edge is looked at, so a held-low line wakes once.
        d.wake = q.ctrl2[C2_WAKE] && LOW_POWER && falling;

        d.irq = (q.ctrl2[C2_RX_IRQ] && (q.avail || q.overrun))
                || (q.ctrl2[C2_IDLE_IRQ] && TX_IDLE)
                || (q.ctrl2[C2_EMPTY_IRQ] && q.empty);

        d.gap = q.tick ? 15'h0001 : q.gap + 15'h0001;
        if (cfg_wr || !en) begin
            d.clean = 1'b0;
        end else if (q.tick) begin
            d.clean = 1'b1;
        end
    end

    // Divisor and data reset to zero; software must still program them.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            q         <= '0;
            q.ctrl1   <= CTRL_ONE_RESET;
            q.ctrl2   <= CTRL_TWO_RESET;
            q.divisor <= DIVISOR_RESET;
            q.rx_data <= DATA_RESET;
            q.empty   <= 1'b1;
            q.rx_sync <= 2'b11;
            q.rx_last <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign RDATA       = q.rdata;
    assign WAKE_REQ    = q.wake;
    assign BAUD_TICK   = q.tick;
    assign PORT_ACTIVE = en;
    assign DATA_NINE   = nine;
    assign IRQ_REQ     = q.irq;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);

    a_baud_period: assert property (
        q.tick && q.clean && !cfg_wr |->
        q.gap == (q.ctrl2[C2_HIGH_SPEED] ? 15'd16 : 15'd64)
                 * ({7'h00, q.divisor} + 15'd1))
        else $error("baud period does not match divisor and speed");

    a_timer_reload: assert property (
        en && q.timer == 8'h00 && !WR_STB |=> q.timer == $past(q.divisor))
        else $error("baud timer did not reload the divisor");

    a_addr_word: assert property (
        RX_VALID && en && q.ctrl2[C2_ADDR_DET] && addr_bit && !q.avail
        ##1 en && q.ctrl2[C2_RX_IRQ] && !rd_data |=> IRQ_REQ)
        else $error("address word raised no interrupt request");

    a_addr_discard: assert property (
        RX_VALID && en && q.ctrl2[C2_ADDR_DET] && !addr_bit && !rd_data |=>
        q.rx_data == $past(q.rx_data) && q.avail == $past(q.avail))
        else $error("data word kept while address detect is on");

    a_wake_edge: assert property (
        q.ctrl2[C2_WAKE] && LOW_POWER && falling |=> WAKE_REQ)
        else $error("falling edge did not wake");

    a_wake_block: assert property (
        WAKE_REQ |-> $past(q.ctrl2[C2_WAKE]) && $past(LOW_POWER))
        else $error("wake raised while wake-up is disabled");

    a_rx_irq: assert property (
        q.ctrl2[C2_RX_IRQ] && (q.avail || q.overrun) |=> IRQ_REQ)
        else $error("receive flag did not request interrupt");

    a_irq_cause: assert property (
        IRQ_REQ |-> $past(q.ctrl2[C2_RX_IRQ] && (q.avail || q.overrun)
                          || q.ctrl2[C2_IDLE_IRQ] && TX_IDLE
                          || q.ctrl2[C2_EMPTY_IRQ] && q.empty))
        else $error("interrupt request without enabled source");

    a_empty_clear: assert property (
        $fell(q.empty) |-> $past(wr_data && q.armed))
        else $error("empty flag cleared without status read and write");

    a_disable_flush: assert property (
        !en && !WR_STB |=> !TX_VALID && !q.avail && q.empty
                           && q.divisor == $past(q.divisor))
        else $error("disable did not flush or changed divisor");

    a_data_read: assert property (
        rd_data |=> RDATA == $past(q.rx_data)
                    ##1 (RDATA == 8'h00 || $past(RD_STB)))
        else $error("data read returned wrong byte or held too long");

    c_baud_tick: cover property (q.tick && q.clean);
    c_wake: cover property (WAKE_REQ);
    c_addr_word: cover property (accept && q.ctrl2[C2_ADDR_DET]);
    c_fifo_full: cover property (wr_data && en && !fifo_ready);
endmodule

// File: sim/remote_link.sv
`timescale 1ns/1ps
module remote_link (
    input  wire logic       clk,
    input  wire logic [8:0] tx_word,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic            tx_idle,
    output logic            rx_pin,
    output logic [8:0]      rx_word,
    output logic            rx_valid
);
    logic [8:0] got[$];
    logic       stall = 1'b1;
    logic [3:0] busy  = 4'h0;
    // A taken word keeps the shifter busy, so hand-offs are never back to back.
    assign tx_ready = !stall && busy == 4'h0;
    assign tx_idle  = busy == 4'h0;
    initial begin
        rx_pin   = 1'b1;
        rx_word  = 9'h000;
        rx_valid = 1'b0;
    end
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_word);
            busy <= 4'h9;
        end else if (busy != 4'h0) begin
            busy <= busy - 4'h1;
        end
    end
    // The line idles high through its pull-up; a start bit pulls it low.
    task automatic send(input logic [8:0] w);
        @(posedge clk);
        rx_pin   <= 1'b0;
        rx_word  <= w;
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_word  <= ~w;
        repeat (4) @(posedge clk);
        rx_pin   <= 1'b1;
    endtask
endmodule

// File: sim/tb_uart_baud_addr_irq_ctrl.sv
`timescale 1ns/1ps
module tb_uart_baud_addr_irq_ctrl
    import uart_ctrl_pkg::*;
;
    logic              clk_sys   = 1'b0;
    logic              rstn      = 1'b0;
    logic [ADDR_W-1:0] addr      = '0;
    logic [DATA_W-1:0] wdata     = '0;
    logic              wr_stb    = 1'b0;
    logic              rd_stb    = 1'b0;
    logic              low_power = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              wake_req, baud_tick, port_active, data_nine;
    logic              tx_valid, tx_ready, tx_idle, rx_pin, rx_valid;
    logic              irq_req;
    logic [WORD_W-1:0] tx_word, rx_word, w;
    logic [7:0]        seed = 8'h5e;
    logic [7:0]        n;
    logic              hs;
    logic              ok;
    logic [8:0]        exp_q[$];
    int                bad_count = 0;
    int                n_checks  = 0;
    int                wakes     = 0;
    int                cnt;
    int                w0;

    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (wake_req === 1'b1) begin
            wakes++;
        end
    end

    uart_baud_addr_irq_ctrl #(.FIFO_DEPTH(FIFO_DEPTH_DEF))
        i_uart_baud_addr_irq_ctrl (
        .CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
        .RX_PIN(rx_pin), .LOW_POWER(low_power), .WAKE_REQ(wake_req),
        .BAUD_TICK(baud_tick), .PORT_ACTIVE(port_active),
        .DATA_NINE(data_nine), .TX_WORD(tx_word), .TX_VALID(tx_valid),
        .TX_READY(tx_ready), .TX_IDLE(tx_idle), .RX_WORD(rx_word),
        .RX_VALID(rx_valid), .IRQ_REQ(irq_req));

    remote_link i_remote_link (
        .clk(clk_sys), .tx_word(tx_word), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_idle(tx_idle), .rx_pin(rx_pin),
        .rx_word(rx_word), .rx_valid(rx_valid));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic int period(input logic h, input logic [7:0] v);
        return (h ? PRESCALE_HIGH : PRESCALE_LOW) * (int'(v) + 1);
    endfunction
    // Only address words survive while detection is on.
    function automatic logic keep(input logic nine, input logic adet,
                                  input logic [8:0] x);
        return !adet || (nine ? x[8] : x[7]);
    endfunction

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic limit(input int c, input int lim);
        if (c >= lim) begin
            bad_count++;
            test_done();
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        chk(16'(rdata), 16'(e));
    endtask
    task automatic wait_tick(output int c);
        c = 0;
        do begin
            @(posedge clk_sys);
            c++;
            #1;
        end while (baud_tick !== 1'b1 && c < 20000);
        limit(c, 20000);
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        rdc(OFS_CTRL_ONE, 8'h00);
        rdc(OFS_CTRL_TWO, 8'h00);
        rdc(OFS_STATUS, 8'h03);
        rdc(OFS_DATA, DATA_RESET);
        rdc(OFS_DIVISOR, DIVISOR_RESET);
        rdc(3'h5, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            n = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : seed;
            hs = i[0];
            wr(OFS_CTRL_ONE, 8'h00);
            wr(OFS_DIVISOR, n);
            wr(OFS_CTRL_TWO, {2'b00, hs, 5'h00});
            wr(OFS_CTRL_ONE, 8'h80);
            wait_tick(cnt);
            wait_tick(cnt);
            chk(16'(cnt), 16'(period(hs, n)));
        end
        wr(OFS_CTRL_ONE, 8'h00);
        #1;
        chk(16'(port_active), 16'h0);
        rdc(OFS_DIVISOR, n);
        rdc(OFS_CTRL_TWO, {2'b00, hs, 5'h00});
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            w = {i[2] & i[0], seed};
            if (!i[2]) begin
                w[7] = i[0];
            end
            ok = keep(i[2], i[1], w);
            wr(OFS_CTRL_ONE, {1'b1, i[2], 6'h00});
            wr(OFS_CTRL_TWO, {3'b000, i[1], 4'h4});
            i_remote_link.send(w);
            #1;
            chk(16'(irq_req), 16'(ok));
            rdc(OFS_STATUS, {5'h00, ok, 2'b11});
            if (ok) begin
                rdc(OFS_DATA, w[7:0]);
                rdc(OFS_CTRL_ONE, {1'b1, i[2], 4'h0, w[8], 1'b0});
            end
            @(posedge clk_sys);
            #1;
            chk(16'(irq_req), 16'h0);
        end
        wr(OFS_CTRL_ONE, 8'h80);
        wr(OFS_CTRL_TWO, 8'h04);
        i_remote_link.send(9'h0a5);
        i_remote_link.send(9'h05a);
        rdc(OFS_STATUS, 8'h0f);
        rdc(OFS_STATUS, 8'h07);
        wr(OFS_CTRL_TWO, 8'h00);
        @(posedge clk_sys);
        #1;
        chk(16'(irq_req), 16'h0);
        rdc(OFS_DATA, 8'ha5);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CTRL_TWO, 8'h02 >> i);
            @(posedge clk_sys);
            #1;
            chk(16'(irq_req), 16'(i != 2));
        end
        // The far side stalls so the fifo fills and the fifth word is lost.
        // Disabling first drops the arm left by the earlier status reads.
        wr(OFS_CTRL_ONE, 8'h41);
        wr(OFS_CTRL_ONE, 8'hc1);
        #1;
        chk(16'({port_active, data_nine}), 16'h3);
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            wr(OFS_DATA, seed);
            if (i < FIFO_DEPTH_DEF) begin
                exp_q.push_back({1'b1, seed});
            end
            if (i == 0) begin
                rdc(OFS_STATUS, 8'h03);
            end
        end
        rdc(OFS_STATUS, 8'h02);
        i_remote_link.stall <= 1'b0;
        cnt = 0;
        while ((i_remote_link.got.size() < 4 || tx_idle !== 1'b1)
               && cnt < 500) begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
        limit(cnt, 500);
        chk(16'(i_remote_link.got.size()), 16'h4);
        foreach (exp_q[k]) begin
            chk(16'(i_remote_link.got[k]), 16'(exp_q[k]));
        end
        rdc(OFS_STATUS, 8'h03);
        for (int i = 0; i < 3; i++) begin
            low_power <= i != 2;
            wr(OFS_CTRL_TWO, (i == 1) ? 8'h00 : 8'h08);
            w0 = wakes;
            i_remote_link.send(9'h055);
            repeat (3) @(posedge clk_sys);
            chk(16'(wakes - w0), 16'(i == 0));
        end
        test_done();
    end
endmodule
